// File: core/iasu_regs.svh
// Register offsets, field positions, reset values and widths of the add/subtract unit.
// Assumes it is included by bare name from files under core/.
// Notes on behaviour
// - Immediate add: (A or zero) plus signed immediate.
// - Shifted immediate add: immediate in upper half.
// - Register add writes A plus B.
// - Reverse subtract writes B minus A.
// - Record variant updates condition field zero only.
// - Overflow variant alone updates overflow and sticky.
// - Immediate carrying add records carry out.
// - Recording immediate carrying add always updates field zero.
// - Immediate carrying subtract: immediate minus A, records carry.
// - Carrying add captures carry out.
// - Carrying reverse subtract captures carry out.
// - Extended add uses carry flag as carry in.
// - Extended reverse subtract takes carry flag as input.
// - Minus-one extended add: A plus carry plus ones.
// - Minus-one extended subtract: not A, carry, all ones.
// - All carrying forms set carry from top bit.
// - Field zero: signed compare of result against zero.
// - Overflow is signed overflow of 32-bit result.
`ifndef IASU_REGS_SVH
`define IASU_REGS_SVH

`define IASU_DATA_W 32
`define IASU_IMM_W 16
`define IASU_GPR_IDX_W 5

// Register byte offsets on the AHB-Lite slave.
`define IASU_OFS_FXR 8'h00
`define IASU_OFS_CFZ 8'h04
`define IASU_OFS_STATUS 8'h08
`define IASU_OFS_CTRL 8'h0C
`define IASU_OFS_OPCOUNT 8'h10

// Fixed-point exception register fields.
`define IASU_FXR_SO_BIT 31
`define IASU_FXR_OVF_BIT 30
`define IASU_FXR_CARRY_BIT 29

// Condition field zero bit order inside its 4-bit field.
`define IASU_CFZ_LT_BIT 3
`define IASU_CFZ_GT_BIT 2
`define IASU_CFZ_EQ_BIT 1
`define IASU_CFZ_STICKY_BIT 0

`define IASU_STATUS_ILLEGAL_BIT 0
`define IASU_CTRL_ENABLE_BIT 0

`define IASU_CTRL_RESET 1'b1
`define IASU_CFZ_RESET 4'h0

`endif

// File: core/iasu_pkg.sv
// Types shared by the add/subtract unit, its checker and its bench.
// Assumes nothing of its surroundings.
package iasu_pkg;

	typedef enum logic [3:0] {
		IASU_OP_ADDI = 4'h0,
		IASU_OP_ADDIS = 4'h1,
		IASU_OP_ADD = 4'h2,
		IASU_OP_SUBF = 4'h3,
		IASU_OP_ADDIC = 4'h4,
		IASU_OP_ADDIC_REC = 4'h5,
		IASU_OP_SUBFIC = 4'h6,
		IASU_OP_ADDC = 4'h7,
		IASU_OP_SUBFC = 4'h8,
		IASU_OP_ADDE = 4'h9,
		IASU_OP_SUBFE = 4'hA,
		IASU_OP_ADDME = 4'hB,
		IASU_OP_SUBFME = 4'hC
	} iasu_op_t;

	typedef enum logic [1:0] {
		IASU_BUS_IDLE = 2'h0,
		IASU_BUS_RDWAIT = 2'h1
	} iasu_bus_st_t;

endpackage : iasu_pkg

// File: core/iasu_add_if.sv
// Operand and result bundle between the unit and its adder.
// Assumes both ends run combinationally in one clock domain.
interface iasu_add_if #(
	parameter int W = 32
);
	logic [W-1:0] opa;
	logic [W-1:0] opb;
	logic cin;
	logic [W-1:0] sum;
	logic cout;
	logic ovf;

	modport user (output opa, output opb, output cin, input sum, input cout, input ovf);
	modport adder (input opa, input opb, input cin, output sum, output cout, output ovf);
endinterface : iasu_add_if

// File: core/iasu_adder.sv
// Three-input adder with carry out and signed overflow.
// Assumes operands are already complemented or extended by the caller.
module iasu_adder #(
	parameter int W = 32
) (
	iasu_add_if.adder add
);
	logic [W:0] full;
	logic [W-1:0] low;

	assign full = {1'b0, add.opa} + {1'b0, add.opb} + {{W{1'b0}}, add.cin};
	assign low = {1'b0, add.opa[W-2:0]} + {1'b0, add.opb[W-2:0]} + {{(W-1){1'b0}}, add.cin};
	assign add.sum = full[W-1:0];
	assign add.cout = full[W];
	// Carry into the top bit differing from carry out marks signed overflow.
	assign add.ovf = low[W-1] ^ full[W];
endmodule : iasu_adder

// File: core/iasu_top.sv
// Integer add/subtract unit with its flag registers and an AHB-Lite register slave.
// Assumes the issue port is driven by decode logic on hclk and a single AHB-Lite master.
`include "iasu_regs.svh"

module iasu_top #(
	parameter int DATA_W = `IASU_DATA_W,
	parameter int IMM_W = `IASU_IMM_W,
	parameter int IDX_W = `IASU_GPR_IDX_W
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	// Issue port from decode.
	input wire logic issue_valid,
	output logic issue_ready,
	input wire iasu_pkg::iasu_op_t issue_op,
	input wire logic issue_record,
	input wire logic issue_ovf_en,
	input wire logic [IDX_W-1:0] issue_src_a_idx,
	input wire logic [DATA_W-1:0] src_a_gpr,
	input wire logic [DATA_W-1:0] src_b_gpr,
	input wire logic [IMM_W-1:0] signed_immediate_field,
	input wire logic [IDX_W-1:0] issue_dest_idx,
	// Writeback port to the register file.
	output logic wb_valid,
	output logic [IDX_W-1:0] wb_dest_idx,
	output logic [DATA_W-1:0] wb_data,
	// Flag state seen by the rest of the core.
	output logic [3:0] condition_field_zero,
	output logic unsigned_wrap_flag,
	output logic signed_wrap_flag,
	output logic sticky_wrap_flag,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);
	iasu_add_if #(.W(DATA_W)) add ();

	iasu_adder #(.W(DATA_W)) u_iasu_adder (
		.add(add)
	);

	logic [DATA_W-1:0] imm_sext;
	logic [DATA_W-1:0] imm_shifted;
	logic [DATA_W-1:0] base_a;
	logic op_legal;
	logic op_carrying;
	logic op_has_ovf;
	logic op_record;
	logic fire;

	logic carry_q;
	logic ovf_q;
	logic so_q;
	logic [3:0] cfz_q;
	logic ctrl_enable_q;
	logic illegal_q;
	logic [31:0] opcount_q;
	logic wb_valid_q;
	logic [IDX_W-1:0] wb_dest_q;
	logic [DATA_W-1:0] wb_data_q;

	logic so_next;
	logic [3:0] cfz_next;

	// Bus state.
	iasu_pkg::iasu_bus_st_t bus_st_q;
	logic wr_pend_q;
	logic [7:0] addr_q;
	logic [31:0] hrdata_q;
	logic [31:0] rd_mux;
	logic addr_take;
	logic sw_wr;
	logic sw_wr_fxr;
	logic sw_wr_cfz;
	logic sw_wr_status;
	logic sw_wr_ctrl;

	// Issue is refused while software holds the unit disabled.
	assign issue_ready = ctrl_enable_q;
	assign fire = issue_valid & issue_ready & clk_en;

	// Source A index zero selects constant zero, not register zero, in ADDI and ADDIS.
	assign imm_sext = {{(DATA_W-IMM_W){signed_immediate_field[IMM_W-1]}},
		signed_immediate_field};
	assign imm_shifted = {signed_immediate_field,
		{(DATA_W-IMM_W){1'b0}}};
	assign base_a = (issue_src_a_idx == '0) ? '0 : src_a_gpr;

	always_comb begin
		add.opa = src_a_gpr;
		add.opb = src_b_gpr;
		add.cin = 1'b0;
		op_legal = 1'b1;
		op_carrying = 1'b0;
		op_has_ovf = 1'b0;
		op_record = 1'b0;
		unique case (issue_op)
			iasu_pkg::IASU_OP_ADDI: begin
				add.opa = base_a;
				add.opb = imm_sext;
			end
			iasu_pkg::IASU_OP_ADDIS: begin
				add.opa = base_a;
				add.opb = imm_shifted;
			end
			iasu_pkg::IASU_OP_ADD: begin
				op_has_ovf = 1'b1;
				op_record = issue_record;
			end
			iasu_pkg::IASU_OP_SUBF: begin
				add.opa = ~src_a_gpr;
				add.cin = 1'b1;
				op_has_ovf = 1'b1;
				op_record = issue_record;
			end
			iasu_pkg::IASU_OP_ADDIC: begin
				add.opb = imm_sext;
				op_carrying = 1'b1;
			end
			iasu_pkg::IASU_OP_ADDIC_REC: begin
				add.opb = imm_sext;
				op_carrying = 1'b1;
				op_record = 1'b1;
			end
			iasu_pkg::IASU_OP_SUBFIC: begin
				add.opa = ~src_a_gpr;
				add.opb = imm_sext;
				add.cin = 1'b1;
				op_carrying = 1'b1;
			end
			iasu_pkg::IASU_OP_ADDC: begin
				op_carrying = 1'b1;
				op_has_ovf = 1'b1;
				op_record = issue_record;
			end
			iasu_pkg::IASU_OP_SUBFC: begin
				add.opa = ~src_a_gpr;
				add.cin = 1'b1;
				op_carrying = 1'b1;
				op_has_ovf = 1'b1;
				op_record = issue_record;
			end
			iasu_pkg::IASU_OP_ADDE: begin
				add.cin = carry_q;
				op_carrying = 1'b1;
				op_has_ovf = 1'b1;
				op_record = issue_record;
			end
			iasu_pkg::IASU_OP_SUBFE: begin
				add.opa = ~src_a_gpr;
				add.cin = carry_q;
				op_carrying = 1'b1;
				op_has_ovf = 1'b1;
				op_record = issue_record;
			end
			iasu_pkg::IASU_OP_ADDME: begin
				add.opb = '1;
				add.cin = carry_q;
				op_carrying = 1'b1;
				op_has_ovf = 1'b1;
				op_record = issue_record;
			end
			iasu_pkg::IASU_OP_SUBFME: begin
				add.opa = ~src_a_gpr;
				add.opb = '1;
				add.cin = carry_q;
				op_carrying = 1'b1;
				op_has_ovf = 1'b1;
				op_record = issue_record;
			end
			default: begin
				op_legal = 1'b0;
			end
		endcase
	end

	// The copy of the sticky bit in field zero is the value after this operation.
	assign so_next = (op_has_ovf & issue_ovf_en) ? (so_q | add.ovf) : so_q;

	always_comb begin
		cfz_next = `IASU_CFZ_RESET;
		cfz_next[`IASU_CFZ_LT_BIT] = add.sum[DATA_W-1];
		cfz_next[`IASU_CFZ_GT_BIT] = ~add.sum[DATA_W-1] & (add.sum != '0);
		cfz_next[`IASU_CFZ_EQ_BIT] = (add.sum == '0);
		cfz_next[`IASU_CFZ_STICKY_BIT] = so_next;
	end

	// Writeback is registered: the result shows one edge after issue.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wb_valid_q <= 1'b0;
			wb_dest_q <= '0;
			wb_data_q <= '0;
		end else if (clk_en) begin
			wb_valid_q <= fire & op_legal;
			if (fire & op_legal) begin
				wb_dest_q <= issue_dest_idx;
				wb_data_q <= add.sum;
			end
		end
	end

	// Hardware updates win over a software write landing in the same cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			carry_q <= 1'b0;
		end else if (clk_en) begin
			if (fire & op_legal & op_carrying) begin
				carry_q <= add.cout;
			end else if (sw_wr_fxr) begin
				carry_q <= hwdata[`IASU_FXR_CARRY_BIT];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ovf_q <= 1'b0;
			so_q <= 1'b0;
		end else if (clk_en) begin
			if (fire & op_legal & op_has_ovf & issue_ovf_en) begin
				ovf_q <= add.ovf;
				so_q <= so_next;
			end else if (sw_wr_fxr) begin
				ovf_q <= hwdata[`IASU_FXR_OVF_BIT];
				so_q <= hwdata[`IASU_FXR_SO_BIT];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfz_q <= `IASU_CFZ_RESET;
		end else if (clk_en) begin
			if (fire & op_legal & op_record) begin
				cfz_q <= cfz_next;
			end else if (sw_wr_cfz) begin
				cfz_q <= hwdata[3:0];
			end
		end
	end

	// Illegal opcodes are dropped and leave a sticky mark; write one to clear.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			illegal_q <= 1'b0;
		end else if (clk_en) begin
			if (fire & ~op_legal) begin
				illegal_q <= 1'b1;
			end else if (sw_wr_status & hwdata[`IASU_STATUS_ILLEGAL_BIT]) begin
				illegal_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			opcount_q <= '0;
		end else if (clk_en) begin
			if (fire & op_legal) begin
				opcount_q <= opcount_q + 32'h00000001;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_enable_q <= `IASU_CTRL_RESET;
		end else if (clk_en) begin
			if (sw_wr_ctrl) begin
				ctrl_enable_q <= hwdata[`IASU_CTRL_ENABLE_BIT];
			end
		end
	end

	// AHB-Lite slave: writes finish with no wait, reads take one wait state
	// so that read data comes from a flop and sees a write just before it.
	assign addr_take = hsel & htrans[1] & hready;
	assign sw_wr = wr_pend_q & clk_en;
	assign sw_wr_fxr = sw_wr & (addr_q == `IASU_OFS_FXR);
	assign sw_wr_cfz = sw_wr & (addr_q == `IASU_OFS_CFZ);
	assign sw_wr_status = sw_wr & (addr_q == `IASU_OFS_STATUS);
	assign sw_wr_ctrl = sw_wr & (addr_q == `IASU_OFS_CTRL);

	always_comb begin
		rd_mux = 32'h00000000;
		unique case (addr_q)
			`IASU_OFS_FXR: begin
				rd_mux[`IASU_FXR_SO_BIT] = so_q;
				rd_mux[`IASU_FXR_OVF_BIT] = ovf_q;
				rd_mux[`IASU_FXR_CARRY_BIT] = carry_q;
			end
			`IASU_OFS_CFZ: rd_mux[3:0] = cfz_q;
			`IASU_OFS_STATUS: rd_mux[`IASU_STATUS_ILLEGAL_BIT] = illegal_q;
			`IASU_OFS_CTRL: rd_mux[`IASU_CTRL_ENABLE_BIT] = ctrl_enable_q;
			`IASU_OFS_OPCOUNT: rd_mux = opcount_q;
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bus_st_q <= iasu_pkg::IASU_BUS_IDLE;
			wr_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end else if (clk_en) begin
			wr_pend_q <= addr_take & hwrite;
			if (addr_take) begin
				addr_q <= {haddr[7:2], 2'b00};
			end
			unique case (bus_st_q)
				iasu_pkg::IASU_BUS_IDLE: begin
					if (addr_take & ~hwrite) begin
						bus_st_q <= iasu_pkg::IASU_BUS_RDWAIT;
					end
				end
				iasu_pkg::IASU_BUS_RDWAIT: begin
					bus_st_q <= iasu_pkg::IASU_BUS_IDLE;
				end
				default: begin
					bus_st_q <= iasu_pkg::IASU_BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h00000000;
		end else if (clk_en) begin
			if (bus_st_q == iasu_pkg::IASU_BUS_RDWAIT) begin
				hrdata_q <= rd_mux;
			end
		end
	end

	// Only word transfers are supported; hsize is accepted but not checked.
	assign hreadyout = (bus_st_q == iasu_pkg::IASU_BUS_IDLE);
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	assign wb_valid = wb_valid_q;
	assign wb_dest_idx = wb_dest_q;
	assign wb_data = wb_data_q;
	assign condition_field_zero = cfz_q;
	assign unsigned_wrap_flag = carry_q;
	assign signed_wrap_flag = ovf_q;
	assign sticky_wrap_flag = so_q;

endmodule : iasu_top

// File: tb/iasu_properties.sv
// Concurrent checks on the issue, writeback and flag ports of the add/subtract unit.
// Assumes the flag registers are not written over the bus while operations are issued.
module iasu_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic issue_valid,
	input wire logic issue_ready,
	input wire iasu_pkg::iasu_op_t issue_op,
	input wire logic issue_record,
	input wire logic issue_ovf_en,
	input wire logic [4:0] issue_src_a_idx,
	input wire logic [31:0] src_a_gpr,
	input wire logic [31:0] src_b_gpr,
	input wire logic [15:0] signed_immediate_field,
	input wire logic wb_valid,
	input wire logic [31:0] wb_data,
	input wire logic [3:0] condition_field_zero,
	input wire logic unsigned_wrap_flag,
	input wire logic signed_wrap_flag,
	input wire logic sticky_wrap_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic acc, immf, recf;
	logic [31:0] base0, imm_sx;
	logic [32:0] sum_ab;
	logic carry_ab;
	assign acc = issue_valid && issue_ready && clk_en;
	assign immf = issue_op inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h6};
	// Illegal codes never write back, so they must not count as recording.
	assign recf = issue_op < 4'hD && (issue_record && !immf || issue_op == 4'h5);
	assign base0 = issue_src_a_idx == 5'h0 ? 32'h0 : src_a_gpr;
	assign imm_sx = {{16{signed_immediate_field[15]}}, signed_immediate_field};
	assign sum_ab = {1'b0, src_a_gpr} + {1'b0, src_b_gpr};
	assign carry_ab = sum_ab[32];
	sequence s_op(iasu_pkg::iasu_op_t op);
		acc && issue_op == op;
	endsequence
	sequence s_rec;
		acc && recf;
	endsequence
	a_add_sum: assert property (s_op(iasu_pkg::IASU_OP_ADD) |=>
		wb_valid && wb_data == $past(src_a_gpr) + $past(src_b_gpr)) else $error("add wrong");
	a_subf_diff: assert property (s_op(iasu_pkg::IASU_OP_SUBF) |=>
		wb_data == $past(src_b_gpr) - $past(src_a_gpr)) else $error("subtract wrong");
	a_addi_zero: assert property (s_op(iasu_pkg::IASU_OP_ADDI) |=>
		wb_data == $past(base0) + $past(imm_sx)) else $error("immediate add wrong");
	a_addis_high: assert property (s_op(iasu_pkg::IASU_OP_ADDIS) |=>
		wb_data == $past(base0) + {$past(signed_immediate_field), 16'h0000}) else $error("addis");
	a_adde_cin: assert property (s_op(iasu_pkg::IASU_OP_ADDE) |=>
		wb_data == $past(src_a_gpr) + $past(src_b_gpr) + $past(unsigned_wrap_flag))
		else $error("extended add wrong");
	a_addc_carry: assert property (s_op(iasu_pkg::IASU_OP_ADDC) |=>
		unsigned_wrap_flag == $past(carry_ab)) else $error("carry wrong");
	a_cfz_sign: assert property (s_rec |=> condition_field_zero == {wb_data[31],
		!wb_data[31] && wb_data != 32'h0, wb_data == 32'h0, sticky_wrap_flag})
		else $error("field zero wrong");
	a_cfz_kept: assert property (acc && !recf |=> $stable(condition_field_zero))
		else $error("field zero changed");
	a_ov_kept: assert property (acc && !(issue_ovf_en && !immf) |=>
		$stable(signed_wrap_flag) && $stable(sticky_wrap_flag)) else $error("overflow changed");
	a_sticky_on: assert property ($rose(signed_wrap_flag) |-> sticky_wrap_flag)
		else $error("sticky not set");
	a_sticky_stays: assert property (sticky_wrap_flag && acc |=> sticky_wrap_flag)
		else $error("sticky cleared");
endmodule : iasu_checker

bind iasu_top iasu_checker u_iasu_checker (.hclk, .hresetn, .clk_en, .issue_valid,
	.issue_ready, .issue_op, .issue_record, .issue_ovf_en, .issue_src_a_idx, .src_a_gpr,
	.src_b_gpr, .signed_immediate_field, .wb_valid, .wb_data, .condition_field_zero,
	.unsigned_wrap_flag, .signed_wrap_flag, .sticky_wrap_flag);

// File: tb/iasu_gpr_model.sv
// Register file model that feeds source operands and takes writebacks.
// Assumes the bench loads its contents and never reads a register it has just written.
module iasu_gpr_model (
	input wire logic hclk,
	input wire logic [4:0] a_idx,
	input wire logic [4:0] b_idx,
	input wire logic wb_valid,
	input wire logic [4:0] wb_dest_idx,
	input wire logic [31:0] wb_data,
	output logic [31:0] a_val,
	output logic [31:0] b_val
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [32];
	assign a_val = mem[a_idx];
	assign b_val = mem[b_idx];
	always @(posedge hclk) begin
		if (wb_valid === 1'b1) begin
			mem[wb_dest_idx] <= wb_data;
		end
	end
endmodule : iasu_gpr_model

// File: tb/iasu_top_tb.sv
// Self-checking bench: random back-to-back issue traffic plus register accesses.
// Assumes the register file model and the bound checker sit beside it.
module iasu_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, issue_valid, issue_ready, issue_record, issue_ovf_en, wb_valid;
	logic unsigned_wrap_flag, signed_wrap_flag, sticky_wrap_flag, hwrite, hreadyout;
	logic m_en, m_cy, m_ovf, m_so, clk_en, hresp;
	iasu_pkg::iasu_op_t issue_op;
	logic [4:0] issue_src_a_idx, b_idx, issue_dest_idx, wb_dest_idx;
	logic [31:0] src_a_gpr, src_b_gpr, wb_data, hwdata, hrdata, rd, m_cnt;
	logic [15:0] signed_immediate_field;
	logic [3:0] condition_field_zero, m_cr;
	logic [7:0] haddr;
	logic [1:0] htrans;
	int error_cnt, samples_checked;
	logic [43:0] expq [$];
	iasu_top u_iasu_top (.hclk, .hresetn, .clk_en, .issue_valid, .issue_ready,
		.issue_op, .issue_record, .issue_ovf_en, .issue_src_a_idx, .src_a_gpr, .src_b_gpr,
		.signed_immediate_field, .issue_dest_idx, .wb_valid, .wb_dest_idx, .wb_data,
		.condition_field_zero, .unsigned_wrap_flag, .signed_wrap_flag, .sticky_wrap_flag,
		.hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hreadyout, .hresp, .hrdata);
	iasu_gpr_model u_iasu_gpr_model (.hclk, .a_idx(issue_src_a_idx), .b_idx, .wb_valid,
		.wb_dest_idx, .wb_data, .a_val(src_a_gpr), .b_val(src_b_gpr));
	task automatic check(input string what, input logic [43:0] exp, input logic [43:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic results;
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : results
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		check("bus response", 44'h0, hresp);
	endtask : ahb
	// Called just after a rising edge; returns after the edge that takes the operation.
	task automatic issue(input logic [3:0] op, input logic rec, input logic oe);
		logic [4:0] ai, bi, di;
		logic [15:0] im;
		logic [31:0] a, x, y, sx;
		logic [32:0] s;
		logic c, immf;
		ai = 5'($urandom % 16);
		bi = 5'($urandom % 16);
		di = 5'(16 + $urandom % 16);
		im = 16'($urandom);
		a = u_iasu_gpr_model.mem[ai];
		sx = {{16{im[15]}}, im};
		immf = op inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h6};
		x = (op < 4'h2 && ai == 5'h0) ? 32'h0 : a;
		x = (op inside {4'h3, 4'h6, 4'h8, 4'hA, 4'hC}) ? ~a : x;
		y = (op inside {4'h0, 4'h4, 4'h5, 4'h6}) ? sx : (op == 4'h1 ? {im, 16'h0000}
			: (op > 4'hA ? 32'hFFFFFFFF : u_iasu_gpr_model.mem[bi]));
		c = op > 4'h8 ? m_cy : op inside {4'h3, 4'h6, 4'h8};
		s = {1'b0, x} + {1'b0, y} + 33'(c);
		if (m_en && op < 4'hD) begin
			m_cnt++;
			if (op > 4'h3)
				m_cy = s[32];
			if (oe && !immf) begin
				m_ovf = x[31] == y[31] && s[31] != x[31];
				m_so = m_so | m_ovf;
			end
			if (rec && !immf || op == 4'h5)
				m_cr = {s[31], !s[31] && s[31:0] != 32'h0, s[31:0] == 32'h0, m_so};
			expq.push_back({di, s[31:0], m_cr, m_cy, m_ovf, m_so});
		end
		issue_valid <= 1'b1;
		issue_op <= iasu_pkg::iasu_op_t'(op);
		issue_record <= rec;
		issue_ovf_en <= oe;
		issue_src_a_idx <= ai;
		b_idx <= bi;
		signed_immediate_field <= im;
		issue_dest_idx <= di;
		@(posedge hclk);
	endtask : issue
	always @(posedge hclk) begin
		if (wb_valid === 1'b1) begin
			if (expq.size() == 0)
				check("stray writeback", 44'h0, 44'h1);
			else
				check("writeback", expq.pop_front(), {wb_dest_idx, wb_data, condition_field_zero,
					unsigned_wrap_flag, signed_wrap_flag, sticky_wrap_flag});
		end
	end
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	initial begin
		#50000;
		error_cnt++;
		results();
	end
	initial begin
		{hresetn, issue_valid, issue_record, issue_ovf_en, hwrite, m_cy, m_ovf, m_so} = 8'h00;
		clk_en = 1'b1;
		{issue_src_a_idx, b_idx, issue_dest_idx, signed_immediate_field} = 31'h0;
		{hwdata, haddr, htrans, m_cnt, m_cr} = 78'h0;
		issue_op = iasu_pkg::IASU_OP_ADDI;
		m_en = 1'b1;
		error_cnt = 0;
		samples_checked = 0;
		void'($urandom(32'h9678));
		for (int i = 0; i < 32; i++)
			u_iasu_gpr_model.mem[i] = $urandom;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, 8'h0C, 32'h0);
		check("enable reset", 44'h1, rd);
		ahb(1'b0, 8'h40, 32'h0);
		check("unmapped read", 44'h0, rd);
		for (int i = 0; i < 150; i++)
			issue(i < 26 ? 4'(i % 13) : 4'($urandom % 13), 1'($urandom), 1'($urandom));
		issue_valid <= 1'b0;
		ahb(1'b0, 8'h00, 32'h0);
		check("flag bits", {m_so, m_ovf, m_cy}, rd[31:29]);
		ahb(1'b1, 8'h00, 32'h0);
		{m_so, m_ovf, m_cy} = 3'h0;
		ahb(1'b1, 8'h0C, 32'h0);
		m_en = 1'b0;
		#1 check("ready off", 44'h0, issue_ready);
		issue(4'h2, 1'b1, 1'b1);
		issue_valid <= 1'b0;
		ahb(1'b1, 8'h0C, 32'h1);
		// A frozen clock enable must swallow the offered operation entirely.
		clk_en <= 1'b0;
		issue(4'h2, 1'b1, 1'b1);
		clk_en <= 1'b1;
		m_en = 1'b1;
		issue(4'h9, 1'b1, 1'b1);
		issue(4'hD, 1'b1, 1'b1);
		issue_valid <= 1'b0;
		ahb(1'b0, 8'h08, 32'h0);
		check("illegal flag", 44'h1, rd[0]);
		ahb(1'b0, 8'h10, 32'h0);
		check("op count", m_cnt, rd);
		repeat (3) @(posedge hclk);
		check("pending results", 44'h0, 44'(expq.size()));
		results();
	end
endmodule : iasu_top_tb
